// ===== verilog/rate_cfg_pkg.sv
`default_nettype none
package rate_cfg_pkg;
   // decimation of the modulator stream: 1024 = 2**10
   localparam int DEC_SHIFT = 10;
   localparam int PERIOD_W = 23;
   localparam int CODE_W = 10;
   localparam logic [CODE_W-1:0] CODE_MIN = 10'h001;
   localparam logic [2:0] ORDER_SINC4 = 3'h4;
   localparam logic [2:0] ORDER_THIRD_ORDER_FILTER_SELECT = 3'h3;
   localparam logic [2:0] ORDER_NONE = 3'h1;
   // settling in output periods once chopped
   localparam logic [2:0] CHOP_SETTLE = 3'h2;
   localparam logic [2:0] ONE_PERIOD = 3'h1;
   localparam logic [PERIOD_W-1:0] COUNT_ONE = 23'h00_0001;
   localparam int FIFTY_HZ = 50;
   localparam int NOMINAL_MCLK_HZ = 4920000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN = 2'b10
   } conv_state_e;

   typedef struct packed {
      logic clock_halve;
      logic single_cycle_enable;
      logic sixty_hertz_notch_enable;
      logic third_order_filter_select;
      logic chop_enable;
      logic fast_settle_enable;
      logic single_conversion_mode;
      logic multi_channel;
      logic [CODE_W-1:0] rate_code;
   } rate_cfg_s;

   typedef struct packed {
      logic [PERIOD_W-1:0] period;
      logic [PERIOD_W-1:0] notch_divisor;
      logic [PERIOD_W:0] chop_notch_divisor;
      logic sixty_notch_active;
      logic single_cycle_active;
   } rate_info_s;
endpackage : rate_cfg_pkg
`default_nettype wire

// ===== verilog/sigma_delta_filter_rate_config.sv
`default_nettype none
//Contract
//R1: halve master clock when halving bit set
//R2: software keeps halving bit clear normally
//R3: software sets halving for low-supply calibration
//R4: software prefers chop and slow rate calibrating
//R5: single-cycle bit gives settled result per period
//R6: single-cycle ignored multi-channel or single-conversion
//R7: with fast settling, single-cycle needs chop
//R8: add 60 Hz notch when first notch 50
//R9: rate code sets cutoff, notch, data rate
//R10: plain rate is clock over 1024 over code
//R11: plain first notch equals output data rate
//R12: chopped rate divides further by sinc order
//R13: chopped first notch is order times rate
//R14: chop notches at odd multiples half rate
//R15: sinc order four by default, three selected
module sigma_delta_filter_rate_config #(
   parameter int MCLK_HZ = rate_cfg_pkg::NOMINAL_MCLK_HZ
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic convert_enable,
   input wire rate_cfg_pkg::rate_cfg_s cfg,
   output logic mod_tick,
   output logic data_ready,
   output logic result_settled,
   output logic code_valid,
   output rate_cfg_pkg::rate_info_s info
);
   // rate code whose first notch lands on 50 Hz at full clock
   localparam logic [rate_cfg_pkg::CODE_W:0] FIFTY_CODE =
      (rate_cfg_pkg::CODE_W+1)'(MCLK_HZ / ((1 << rate_cfg_pkg::DEC_SHIFT) *
      rate_cfg_pkg::FIFTY_HZ));

   // R15: sinc order pick
   function automatic logic [2:0] sinc_order(input rate_cfg_pkg::rate_cfg_s c);
      sinc_order = c.third_order_filter_select ? rate_cfg_pkg::ORDER_THIRD_ORDER_FILTER_SELECT
                                               : rate_cfg_pkg::ORDER_SINC4;
   endfunction : sinc_order

   // R6: single-cycle bit only acts for one channel in continuous mode
   function automatic logic single_ok(input rate_cfg_pkg::rate_cfg_s c);
      // R7: fast settling masks the bit unless chopped
      single_ok = c.single_cycle_enable && !c.multi_channel &&
                  !c.single_conversion_mode && (!c.fast_settle_enable || c.chop_enable);
   endfunction : single_ok

   logic half_phase;
   rate_cfg_pkg::conv_state_e state;
   logic [rate_cfg_pkg::PERIOD_W-1:0] count;
   logic [2:0] settle_left;
   rate_cfg_pkg::rate_cfg_s cfg_q;
   logic [rate_cfg_pkg::PERIOD_W-1:0] next_base;
   logic [rate_cfg_pkg::PERIOD_W-1:0] next_period;
   logic [2:0] next_mult;
   logic [2:0] latency;
   logic period_end;
   logic restart;
   logic fifty_hit;

   // R1: divide by two via alternating tick; the tick counter and period_end only move on ticks, the idle-to-settle step does not wait for one
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         half_phase <= 1'b0;
      else
         half_phase <= cfg.clock_halve ? !half_phase : 1'b0;
   end
   assign mod_tick = !cfg.clock_halve || half_phase;

   // R10: base divisor is 1024 ticks per code step
   assign next_base = rate_cfg_pkg::PERIOD_W'({cfg.rate_code, {rate_cfg_pkg::DEC_SHIFT{1'b0}}});
   // R12: chopped or fast-settled rates divide again by the order
   assign next_mult = (cfg.chop_enable || cfg.fast_settle_enable) ? sinc_order(cfg)
                                                                  : rate_cfg_pkg::ORDER_NONE;
   assign next_period = rate_cfg_pkg::PERIOD_W'(next_base * next_mult);
   // R8: first notch sits at 50 Hz; halving doubles the equivalent code
   assign fifty_hit = ({1'b0, cfg.rate_code} << cfg.clock_halve) == FIFTY_CODE;
   assign code_valid = cfg.rate_code >= rate_cfg_pkg::CODE_MIN;

   // R9: derived rate figures registered for the datapath
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         info <= '0;
      end
      else
      begin
         info.period <= next_period;
         // R11: plain notch equals the output rate
         // R13: chopped notch is order times the slower rate, same divisor
         info.notch_divisor <= next_base;
         // R14: chop notch spacing: odd multiples of half the data rate
         info.chop_notch_divisor <= cfg.chop_enable ? {next_period, 1'b0} : '0;
         info.sixty_notch_active <= cfg.sixty_hertz_notch_enable && fifty_hit;
         info.single_cycle_active <= single_ok(cfg);
      end
   end

   // any configuration change restarts filter settling
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cfg_q <= '0;
      else
         cfg_q <= cfg;
   end
   assign restart = (cfg_q != cfg) || !convert_enable || !code_valid;

   // settling depth: one period with single-cycle active, else two periods chopped, else order
   assign latency = info.single_cycle_active ? rate_cfg_pkg::ONE_PERIOD
                  : (cfg.chop_enable ? rate_cfg_pkg::CHOP_SETTLE : sinc_order(cfg));
   assign period_end = mod_tick && (count == info.period - rate_cfg_pkg::COUNT_ONE);

   // tick counter over one output period; the period register lags cfg by one cycle,
   // which the restart covers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         count <= '0;
      else if (restart || state == rate_cfg_pkg::ST_IDLE)
         count <= '0;
      else if (period_end)
         count <= '0;
      else if (mod_tick)
         count <= count + rate_cfg_pkg::COUNT_ONE;
   end

   // conversion sequencing
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= rate_cfg_pkg::ST_IDLE;
         settle_left <= 3'h0;
         data_ready <= 1'b0;
         result_settled <= 1'b0;
      end
      else
      begin
         data_ready <= 1'b0;
         if (restart)
         begin
            state <= rate_cfg_pkg::ST_IDLE;
            result_settled <= 1'b0;
         end
         else
         begin
            case (state)
               rate_cfg_pkg::ST_IDLE:
               begin
                  state <= rate_cfg_pkg::ST_SETTLE;
                  settle_left <= latency;
               end
               rate_cfg_pkg::ST_SETTLE:
               begin
                  if (period_end)
                  begin
                     if (settle_left == rate_cfg_pkg::ONE_PERIOD)
                     begin
                        data_ready <= 1'b1;
                        result_settled <= 1'b1;
                        state <= rate_cfg_pkg::ST_RUN;
                        // R5: one-period latency re-settles before every result
                        if (info.single_cycle_active)
                        begin
                           state <= rate_cfg_pkg::ST_SETTLE;
                           settle_left <= latency;
                        end
                     end
                     else
                     begin
                        settle_left <= settle_left - rate_cfg_pkg::ONE_PERIOD;
                     end
                  end
               end
               rate_cfg_pkg::ST_RUN:
               begin
                  // steady stream: one result every output period
                  if (period_end)
                     data_ready <= 1'b1;
               end
               default:
                  state <= rate_cfg_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // R1: halving leaves a gap after every tick
   a_halve_gap: assert property (@(posedge clk) disable iff (!nrst) // R1
      cfg.clock_halve && $past(cfg.clock_halve) && mod_tick |=> !mod_tick || !cfg.clock_halve)
      else $error("halved clock ticked twice");
   // R1: halved clock still ticks
   a_halve_tick: assert property (@(posedge clk) disable iff (!nrst) // R1
      cfg.clock_halve && $past(cfg.clock_halve) && !mod_tick |=> mod_tick || !cfg.clock_halve)
      else $error("halved clock missed a tick");
   // R1: full clock every cycle
   a_full_rate: assert property (@(posedge clk) disable iff (!nrst) // R1
      !cfg.clock_halve |-> mod_tick)
      else $error("full clock missed a tick");
   // R10: plain period length
   a_plain_period: assert property (@(posedge clk) disable iff (!nrst) // R10
      $stable(cfg) && !cfg.chop_enable && !cfg.fast_settle_enable
      |=> info.period == {$past(cfg.rate_code), 10'h000})
      else $error("plain period wrong");
   // R12: chopped period length
   a_chop_period: assert property (@(posedge clk) disable iff (!nrst) // R12
      $stable(cfg) && cfg.chop_enable
      |=> info.period == 23'(({$past(cfg.rate_code), 10'h000}) *
          ($past(cfg.third_order_filter_select) ? 3 : 4)))
      else $error("chopped period wrong");
   // R13: first notch place
   a_notch_place: assert property (@(posedge clk) disable iff (!nrst) // R13
      $stable(cfg) |=> info.notch_divisor == {$past(cfg.rate_code), 10'h000})
      else $error("first notch misplaced");
   // R14: chop notch spacing
   a_chop_notch: assert property (@(posedge clk) disable iff (!nrst) // R14
      $stable(cfg) && cfg.chop_enable |=> info.chop_notch_divisor == {info.period, 1'b0})
      else $error("chop notch spacing wrong");
   // R8: sixty notch cause
   a_sixty_cause: assert property (@(posedge clk) disable iff (!nrst) // R8
      info.sixty_notch_active |-> $past(cfg.sixty_hertz_notch_enable))
      else $error("sixty notch without enable");
   // R6: single-cycle masking
   a_single_mask: assert property (@(posedge clk) disable iff (!nrst) // R6
      $past(cfg.multi_channel) || $past(cfg.single_conversion_mode)
      |-> !info.single_cycle_active)
      else $error("single-cycle not masked");
   // R7: fast settling mask
   a_fast_mask: assert property (@(posedge clk) disable iff (!nrst) // R7
      $past(cfg.fast_settle_enable) && !$past(cfg.chop_enable) |-> !info.single_cycle_active)
      else $error("single-cycle acts under fast settling");
   // R5: only settled results
   a_ready_settled: assert property (@(posedge clk) disable iff (!nrst) // R5
      data_ready |-> result_settled && $past(code_valid) && $past(convert_enable))
      else $error("unsettled result delivered");

   c_plain_ready: cover property (@(posedge clk) disable iff (!nrst)
      data_ready && !cfg.chop_enable);
   c_chop_ready: cover property (@(posedge clk) disable iff (!nrst)
      data_ready && cfg.chop_enable);
   c_single_ready: cover property (@(posedge clk) disable iff (!nrst)
      data_ready && info.single_cycle_active);
   c_sixty: cover property (@(posedge clk) disable iff (!nrst) info.sixty_notch_active);
endmodule : sigma_delta_filter_rate_config
`default_nettype wire

// ===== testbench/sigma_delta_filter_rate_config_bench.sv
`default_nettype none
module sigma_delta_filter_rate_config_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic convert_enable = 1'b0;
   rate_cfg_pkg::rate_cfg_s cfg = '0;
   logic mod_tick;
   logic data_ready;
   logic result_settled;
   logic code_valid;
   rate_cfg_pkg::rate_info_s info;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;

   sigma_delta_filter_rate_config i_dut (
      .clk(clk), .nrst(nrst), .convert_enable(convert_enable), .cfg(cfg),
      .mod_tick(mod_tick), .data_ready(data_ready), .result_settled(result_settled),
      .code_valid(code_valid), .info(info));

   // 40 mhz master clock
   always #12.5 clk = ~clk;

   // hang guard: the whole sequence needs about 32k cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         $display("unexpected timeout: expected 0 seen %0d cycles", cycles);
         final_report();
      end
   end

   task automatic final_report;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   // four-state compare of design values
   task automatic chk_val(input string name, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : chk_val

   // compare of cycle counts measured by the bench
   task automatic chk_cnt(input string name, input int exp, input int got);
      checks_done++;
      if (got != exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_cnt

   function automatic rate_cfg_pkg::rate_cfg_s mk(input logic [7:0] flags,
                                                   input logic [9:0] code);
      return {flags, code};
   endfunction : mk

   // drive just after the edge, then let info take its one-cycle lag
   task automatic set_cfg(input rate_cfg_pkg::rate_cfg_s v);
      @(posedge clk);
      #2 cfg = v;
      repeat (2) @(posedge clk);
      #2;
   endtask : set_cfg

   // cycles until the next data_ready pulse, capped at max
   task automatic time_ready(input int max, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge clk);
         #2 cnt++;
      end
      while (data_ready !== 1'b1 && cnt < max);
   endtask : time_ready

   // first result after latency periods, then one result per period
   task automatic run_rate(input rate_cfg_pkg::rate_cfg_s v, input int per, input int lat,
                           input int mult);
      int lo;
      set_cfg(v);
      lo = per * lat * mult;
      time_ready(20000, n);
      chk_cnt("first_result_in_window", 1, int'(n + 2 >= lo - 2 && n + 2 <= lo + 6));
      chk_val("result_settled", 24'h00_0001, {23'h0, result_settled});
      time_ready(20000, n);
      chk_cnt("result_interval", per * mult, n);
   endtask : run_rate

   // count conversion ticks over eight master clocks
   task automatic count_ticks(output int t);
      t = 0;
      repeat (8)
      begin
         @(posedge clk);
         #2 t += int'(mod_tick === 1'b1);
      end
   endtask : count_ticks

   initial
   begin
      repeat (3) @(posedge clk);
      #2 nrst = 1'b1;
      convert_enable = 1'b1;
      // plain sinc4, code 1
      run_rate(mk(8'h00, 10'h001), 1024, 4, 1);
      chk_val("period", 24'h00_0400, {1'b0, info.period});
      chk_val("notch", 24'h00_0400, {1'b0, info.notch_divisor});
      chk_val("chop_notch", 24'h00_0000, info.chop_notch_divisor);
      count_ticks(n);
      chk_cnt("ticks_full", 8, n);
      // chopped third_order_filter_select, code 1: chop as a calibration would prefer, but at the fastest rate, not a slow one
      run_rate(mk(8'h18, 10'h001), 3072, 2, 1);
      chk_val("notch_chop", 24'h00_0400, {1'b0, info.notch_divisor});
      chk_val("chop_notch", 24'h00_1800, info.chop_notch_divisor);
      // single-cycle settling
      run_rate(mk(8'h40, 10'h001), 1024, 1, 1);
      chk_val("single_active", 24'h00_0001, {23'h0, info.single_cycle_active});
      // dropping convert_enable holds the filter idle and clears settled
      @(posedge clk);
      #2 convert_enable = 1'b0;
      time_ready(2100, n);
      chk_cnt("disabled_idle", 2100, n);
      chk_val("settled_cleared", 24'h00_0000, {23'h0, result_settled});
      convert_enable = 1'b1;
      // halved master clock, as a low-supply calibration needs
      run_rate(mk(8'h80, 10'h001), 1024, 4, 2);
      count_ticks(n);
      chk_cnt("ticks_halved", 4, n);
      // single-cycle masking; halving cleared again for normal conversions
      set_cfg(mk(8'h41, 10'h001));
      chk_val("single_multi", 24'h00_0000, {23'h0, info.single_cycle_active});
      set_cfg(mk(8'h42, 10'h001));
      chk_val("single_oneshot", 24'h00_0000, {23'h0, info.single_cycle_active});
      set_cfg(mk(8'h44, 10'h002));
      chk_val("single_fast", 24'h00_0000, {23'h0, info.single_cycle_active});
      chk_val("period_fast", 24'h00_2000, {1'b0, info.period});
      set_cfg(mk(8'h4c, 10'h002));
      chk_val("single_fast_chop", 24'h00_0001, {23'h0, info.single_cycle_active});
      // sixty hertz notch only with the first notch at 50 hz
      set_cfg(mk(8'h20, 10'h060));
      chk_val("sixty_96", 24'h00_0001, {23'h0, info.sixty_notch_active});
      set_cfg(mk(8'h20, 10'h05f));
      chk_val("sixty_95", 24'h00_0000, {23'h0, info.sixty_notch_active});
      set_cfg(mk(8'ha0, 10'h030));
      chk_val("sixty_halved", 24'h00_0001, {23'h0, info.sixty_notch_active});
      set_cfg(mk(8'h00, 10'h060));
      chk_val("sixty_off", 24'h00_0000, {23'h0, info.sixty_notch_active});
      // code range limits
      set_cfg(mk(8'h00, 10'h3ff));
      chk_val("code_max_valid", 24'h00_0001, {23'h0, code_valid});
      chk_val("period_max", 24'h0f_fc00, {1'b0, info.period});
      set_cfg(mk(8'h00, 10'h000));
      chk_val("code_zero_valid", 24'h00_0000, {23'h0, code_valid});
      time_ready(3000, n);
      chk_cnt("code_zero_idle", 3000, n);
      final_report();
   end
endmodule : sigma_delta_filter_rate_config_bench
`default_nettype wire
